// File: hw/icm_clock_ctrl.sv
// Internal clock mode controller: APB registers, mode selection,
// glitch-free source switch, bus divider and loop frequency control.
// Assumes analog oscillators outside; their outputs arrive as async pins.
//
// Summary of operation
// [RULE1] System clock toggles the bus clock, so bus runs at half its rate.
// [RULE2] Selected source, loop or reference, always passes the divider first.
// [RULE3] Loop control steers oscillator to 512 loop edges per reference period.
// [RULE4] Reference trim is eight coarse bits plus one fine bit.
// [RULE5] A system reset (rst_n) leaves the block in loop engaged mode.
// [RULE6] Loop engaged mode clocks from the loop, regulated by reference.
// [RULE7] Bypass mode keeps loop enabled and regulated, clocks from reference.
// [RULE8] Bypass low power mode disables loop, clocks from reference.
// [RULE9] Stop disables loop and halts the system clock.
// [RULE10] Select bit 6: zero picks loop, one picks reference.
// [RULE11] Keep-alive bit 0 keeps the reference running in stop.
// [RULE12] Divider bits 7:6 divide by 1,2,4,8; resets to divide by 2.
// [RULE13] Low power bit 3 disables the loop in bypass modes.
// [RULE14] Coarse trim bits 7:0, larger value gives longer period.
// [RULE15] Fine trim bit 0 makes the smallest period step.
// [RULE16] Status bit 2 shows source really in use, after synchronising.
// [RULE17] Select one with low power zero gives bypass, both one low power.
// [RULE18] Wake from stop returns to the mode held before stop.
// [RULE19] Divider writes act at once on the running count.
// [RULE20] Trim values survive every system reset.
// [RULE21] Unused register bits read zero and ignore writes.
`timescale 1ns/1ps

module icm_clock_ctrl (
  // Clock and resets
  input wire logic clock,
  input wire logic rst_n,
  input wire logic por_n,
  // APB slave
  input wire icm_pkg::icm_apb_req_t apb_req,
  output icm_pkg::icm_apb_rsp_t apb_rsp,
  // Chip power state
  input wire logic stop_req,
  // Oscillator outputs, asynchronous
  input wire logic ref_osc_in,
  input wire logic loop_osc_in,
  // Clock outputs
  output logic system_clock_out,
  output logic bus_clock_out,
  // Analog controls
  output logic loop_enable,
  output logic ref_enable,
  output logic [9:0] dco_ctrl,
  output logic [8:0] ref_trim,
  output icm_pkg::icm_mode_t clock_mode
);
  import icm_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    icm_apb_rsp_t rsp;
    logic clock_source_select;
    logic reference_stop_keepalive;
    logic [1:0] bus_divider_select;
    logic loop_low_power_disable;
    icm_mode_t mode;
    logic [1:0] sy1;
    logic [1:0] sy2;
    logic [1:0] sy3;
    logic [1:0] lvl;
    logic active_src;
    logic [2:0] div_cnt;
    logic sys_clk;
    logic bus_clk;
    logic loop_en;
    logic ref_en;
    logic [10:0] fcnt;
    logic [9:0] controlled_oscillator_output;
  } icm_state_t;

  icm_state_t s_q;
  icm_state_t s_d;
  logic [8:0] trim_word;
  logic trim_we;
  logic fine_we;

  // ==========================================================
  // Decoding helpers
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic [2:0] half_count(input logic [1:0] div);
    unique case (div)
      2'h0: half_count = 3'h0;
      2'h1: half_count = 3'h1;
      2'h2: half_count = 3'h3;
      2'h3: half_count = 3'h7;
    endcase
  endfunction

  function automatic logic [7:0] read_byte(input icm_state_t s, input logic [3:0] addr,
                                           input logic [8:0] tw);
    logic [7:0] r;
    r = 8'h00;
    if (hit(addr, ICM_OFS_CTRL1))
    begin
      r[ICM_SEL_BIT] = s.clock_source_select;
      r[ICM_KEEP_BIT] = s.reference_stop_keepalive;
    end
    if (hit(addr, ICM_OFS_CTRL2))
    begin
      r[ICM_DIV_LSB +: 2] = s.bus_divider_select;
      r[ICM_LP_BIT] = s.loop_low_power_disable;
    end
    if (hit(addr, ICM_OFS_TRIM))
    begin
      r = tw[8:1];
    end
    if (hit(addr, ICM_OFS_STAT))
    begin
      r[ICM_ST_BIT] = s.active_src;
      r[ICM_FT_BIT] = tw[0];
    end
    read_byte = r;
  endfunction

  // ==========================================================
  // Next state
  logic acc;
  logic wr;
  logic [1:0] evt;
  logic [1:0] rise;
  logic mapped;

  always_comb
  begin
    s_d = s_q;
    evt = 2'b00;
    rise = 2'b00;
    trim_we = 1'b0;
    fine_we = 1'b0;
    acc = apb_req.psel && apb_req.penable;
    wr = acc && s_q.rsp.pready && apb_req.pwrite;
    mapped = hit(apb_req.paddr, ICM_OFS_CTRL1) || hit(apb_req.paddr, ICM_OFS_CTRL2) ||
             hit(apb_req.paddr, ICM_OFS_TRIM) || hit(apb_req.paddr, ICM_OFS_STAT);

    // Bus handshake, one wait state
    s_d.rsp.pready = acc && !s_q.rsp.pready;
    s_d.rsp.pslverr = acc && !s_q.rsp.pready && !mapped;
    if (acc && !s_q.rsp.pready)
    begin
      s_d.rsp.prdata = {24'h000000, read_byte(s_q, apb_req.paddr, trim_word)}; // see [RULE21]
    end

    // Register writes; unused bits dropped
    if (wr && hit(apb_req.paddr, ICM_OFS_CTRL1))
    begin
      s_d.clock_source_select = apb_req.pwdata[ICM_SEL_BIT]; // see [RULE10]
      s_d.reference_stop_keepalive = apb_req.pwdata[ICM_KEEP_BIT]; // see [RULE11]
    end
    if (wr && hit(apb_req.paddr, ICM_OFS_CTRL2))
    begin
      s_d.bus_divider_select = apb_req.pwdata[ICM_DIV_LSB +: 2]; // see [RULE12]
      s_d.loop_low_power_disable = apb_req.pwdata[ICM_LP_BIT]; // see [RULE13]
    end
    trim_we = wr && hit(apb_req.paddr, ICM_OFS_TRIM); // see [RULE14]
    fine_we = wr && hit(apb_req.paddr, ICM_OFS_STAT); // see [RULE15]

    // Mode follows registers; stop leaves them intact for wakeup
    if (stop_req)
    begin
      s_d.mode = ICM_STOP_MODE; // see [RULE9] see [RULE18]
    end
    else if (!s_q.clock_source_select)
    begin
      s_d.mode = ICM_LOOP_ENGAGED_INTERNAL_MODE; // see [RULE6]
    end
    else if (s_q.loop_low_power_disable)
    begin
      s_d.mode = ICM_BYPASS_LOW_POWER_MODE; // see [RULE17] see [RULE8]
    end
    else
    begin
      s_d.mode = ICM_BYPASS_INTERNAL_MODE; // see [RULE17] see [RULE7]
    end

    unique case (s_d.mode)
      ICM_LOOP_ENGAGED_INTERNAL_MODE:
      begin
        s_d.loop_en = 1'b1;
        s_d.ref_en = 1'b1;
      end
      ICM_BYPASS_INTERNAL_MODE:
      begin
        s_d.loop_en = 1'b1; // see [RULE7] see [RULE13]
        s_d.ref_en = 1'b1;
      end
      ICM_BYPASS_LOW_POWER_MODE:
      begin
        s_d.loop_en = 1'b0; // see [RULE8] see [RULE13]
        s_d.ref_en = 1'b1;
      end
      ICM_STOP_MODE:
      begin
        s_d.loop_en = 1'b0; // see [RULE9]
        s_d.ref_en = s_q.reference_stop_keepalive; // see [RULE11]
      end
    endcase

    // Oscillator synchronisers; a level counts once stages two and three agree
    s_d.sy1 = {loop_osc_in, ref_osc_in};
    s_d.sy2 = s_q.sy1;
    s_d.sy3 = s_q.sy2;
    for (int i = 0; i < 2; i++)
    begin
      if (s_q.sy2[i] == s_q.sy3[i])
      begin
        s_d.lvl[i] = s_q.sy3[i];
      end
      evt[i] = s_d.lvl[i] != s_q.lvl[i];
      rise[i] = s_d.lvl[i] && !s_q.lvl[i];
    end

    // Divider on both edges of the active source; halted in stop
    if (s_q.mode != ICM_STOP_MODE && evt[s_q.active_src ? ICM_REF : ICM_LOOP])
    begin
      if (s_q.div_cnt >= half_count(s_q.bus_divider_select)) // see [RULE19] see [RULE2]
      begin
        s_d.div_cnt = 3'h0;
        s_d.sys_clk = !s_q.sys_clk; // see [RULE12]
        // Swap source only as the output falls, so no runt pulse
        if (s_q.sys_clk && s_q.active_src != s_q.clock_source_select)
        begin
          s_d.active_src = s_q.clock_source_select; // see [RULE16] see [RULE10]
        end
      end
      else
      begin
        s_d.div_cnt = s_q.div_cnt + 3'h1;
      end
    end
    if (s_d.sys_clk && !s_q.sys_clk)
    begin
      s_d.bus_clk = !s_q.bus_clk; // see [RULE1]
    end

    // Frequency lock: count loop edges per reference period
    if (s_q.loop_en)
    begin
      if (rise[ICM_REF])
      begin
        s_d.fcnt = 11'h000;
        if (s_q.fcnt < ICM_LOOP_MULT && s_q.controlled_oscillator_output != ICM_DCO_MAX)
        begin
          s_d.controlled_oscillator_output = s_q.controlled_oscillator_output + 10'h001; // see [RULE3]
        end
        else if (s_q.fcnt > ICM_LOOP_MULT && s_q.controlled_oscillator_output != 10'h000)
        begin
          s_d.controlled_oscillator_output = s_q.controlled_oscillator_output - 10'h001; // see [RULE3]
        end
      end
      else if (rise[ICM_LOOP] && s_q.fcnt != ICM_FCNT_MAX)
      begin
        s_d.fcnt = s_q.fcnt + 11'h001;
      end
    end
    else
    begin
      s_d.fcnt = 11'h000;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.rsp <= '0;
      s_q.clock_source_select <= ICM_SEL_RST;
      s_q.reference_stop_keepalive <= ICM_KEEP_RST;
      s_q.bus_divider_select <= ICM_DIV_RST; // see [RULE12]
      s_q.loop_low_power_disable <= ICM_LP_RST;
      s_q.mode <= ICM_LOOP_ENGAGED_INTERNAL_MODE; // see [RULE5]
      s_q.sy1 <= 2'b00;
      s_q.sy2 <= 2'b00;
      s_q.sy3 <= 2'b00;
      s_q.lvl <= 2'b00;
      s_q.active_src <= ICM_SEL_RST;
      s_q.div_cnt <= 3'h0;
      s_q.sys_clk <= 1'b0;
      s_q.bus_clk <= 1'b0;
      s_q.loop_en <= 1'b1;
      s_q.ref_en <= 1'b1;
      s_q.fcnt <= 11'h000;
      s_q.controlled_oscillator_output <= ICM_DCO_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Trim held on power-on reset only
  icm_trim_store u_trim (
    .clock(clock),
    .por_n(por_n), // see [RULE20]
    .trim_we(trim_we),
    .fine_we(fine_we),
    .wdata(apb_req.pwdata[7:0]),
    .trim_word(trim_word) // see [RULE4]
  );

  assign apb_rsp = s_q.rsp;
  assign system_clock_out = s_q.sys_clk;
  assign bus_clock_out = s_q.bus_clk;
  assign loop_enable = s_q.loop_en;
  assign ref_enable = s_q.ref_en;
  assign dco_ctrl = s_q.controlled_oscillator_output;
  assign ref_trim = trim_word;
  assign clock_mode = s_q.mode;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_BUS_HALF: assert property ( // see [RULE1]
    $rose(s_q.sys_clk) |-> s_q.bus_clk != $past(s_q.bus_clk))
    else $error("bus clock did not toggle on system clock rise");

  AST_STOP_HALT: assert property ( // see [RULE9]
    s_q.mode == ICM_STOP_MODE ##1 s_q.mode == ICM_STOP_MODE |-> $stable(s_q.sys_clk))
    else $error("system clock moved in stop");

  AST_STOP_LOOP: assert property ( // see [RULE9]
    stop_req |=> s_q.mode == ICM_STOP_MODE && !s_q.loop_en)
    else $error("loop enabled in stop");

  AST_KEEPALIVE: assert property ( // see [RULE11]
    s_q.mode == ICM_STOP_MODE |-> s_q.ref_en == $past(s_q.reference_stop_keepalive))
    else $error("reference enable wrong in stop");

  AST_LOW_POWER: assert property ( // see [RULE13]
    !stop_req && s_q.clock_source_select && s_q.loop_low_power_disable |=> !s_q.loop_en)
    else $error("loop enabled in bypass low power");

  AST_BYPASS_MODE: assert property ( // see [RULE17]
    !stop_req && s_q.clock_source_select && !s_q.loop_low_power_disable
      |=> s_q.mode == ICM_BYPASS_INTERNAL_MODE && s_q.loop_en)
    else $error("bypass mode not entered");

  AST_STATUS_LAG: assert property ( // see [RULE16]
    $rose(s_q.clock_source_select) |-> !s_q.active_src)
    else $error("status followed select at once");

  AST_READ_ZERO: assert property ( // see [RULE21]
    s_q.rsp.pready |-> s_q.rsp.prdata[31:8] == 24'h000000)
    else $error("unused read bits not zero");

  AST_LOCK_UP: assert property ( // see [RULE3]
    s_q.loop_en && rise[ICM_REF] && s_q.fcnt < ICM_LOOP_MULT && s_q.controlled_oscillator_output != ICM_DCO_MAX
      |=> s_q.controlled_oscillator_output == $past(s_q.controlled_oscillator_output) + 10'h001)
    else $error("loop control did not step up");

  AST_PREADY: assert property (
    apb_req.psel && apb_req.penable && !s_q.rsp.pready |=> s_q.rsp.pready ##1 !s_q.rsp.pready)
    else $error("ready not a single pulse");

endmodule

// File: hw/icm_pkg.sv
// Package for the internal clock mode controller: register map,
// field positions, reset values, mode codes and bus carriers.
// Assumes a 32-bit APB master with word-aligned byte addresses.
package icm_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [3:0] ICM_OFS_CTRL1 = 4'h0;
  localparam logic [3:0] ICM_OFS_CTRL2 = 4'h4;
  localparam logic [3:0] ICM_OFS_TRIM = 4'h8;
  localparam logic [3:0] ICM_OFS_STAT = 4'hc;

  // ==========================================================
  // Field positions
  localparam int ICM_SEL_BIT = 6;
  localparam int ICM_KEEP_BIT = 0;
  localparam int ICM_DIV_LSB = 6;
  localparam int ICM_LP_BIT = 3;
  localparam int ICM_ST_BIT = 2;
  localparam int ICM_FT_BIT = 0;

  // ==========================================================
  // Reset values and counts
  localparam logic [1:0] ICM_DIV_RST = 2'h1;
  localparam logic ICM_SEL_RST = 1'b0;
  localparam logic ICM_LP_RST = 1'b0;
  localparam logic ICM_KEEP_RST = 1'b0;
  localparam logic [7:0] ICM_TRIM_RST = 8'h80;
  localparam logic ICM_FT_RST = 1'b0;
  localparam logic [9:0] ICM_DCO_RST = 10'h200;
  localparam logic [9:0] ICM_DCO_MAX = 10'h3ff;
  localparam logic [10:0] ICM_LOOP_MULT = 11'h200;
  localparam logic [10:0] ICM_FCNT_MAX = 11'h7ff;

  // Source index in the synchroniser vectors
  localparam int ICM_REF = 0;
  localparam int ICM_LOOP = 1;

  // ==========================================================
  // Operating modes
  typedef enum logic [1:0] {
    ICM_LOOP_ENGAGED_INTERNAL_MODE = 2'b00,
    ICM_BYPASS_INTERNAL_MODE = 2'b01,
    ICM_BYPASS_LOW_POWER_MODE = 2'b10,
    ICM_STOP_MODE = 2'b11
  } icm_mode_t;

  // ==========================================================
  // APB carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [3:0] paddr;
    logic [31:0] pwdata;
  } icm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } icm_apb_rsp_t;

endpackage

// File: hw/icm_trim_store.sv
// Trim storage for the internal reference: eight coarse bits and one
// fine bit. Reset only by power-on, so system resets keep the trim.
`timescale 1ns/1ps

module icm_trim_store (
  // Clock and power-on reset
  input wire logic clock,
  input wire logic por_n,
  // Write strobes and data
  input wire logic trim_we,
  input wire logic fine_we,
  input wire logic [7:0] wdata,
  // Stored trim, {coarse, fine}
  output logic [8:0] trim_word
);
  import icm_pkg::*;

  typedef struct packed {
    logic [7:0] trim;
    logic fine;
  } icm_trim_t;

  icm_trim_t s_q;
  icm_trim_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (trim_we)
    begin
      s_d.trim = wdata;
    end
    if (fine_we)
    begin
      s_d.fine = wdata[ICM_FT_BIT];
    end
  end

  always_ff @(posedge clock or negedge por_n)
  begin
    if (!por_n)
    begin
      s_q.trim <= ICM_TRIM_RST;
      s_q.fine <= ICM_FT_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign trim_word = {s_q.trim, s_q.fine};

endmodule

// File: tb/icm_clock_ctrl_tb.sv
// Self-checking bench for the clock controller over APB.
// Assumes the oscillator model periods below: loop 60 ns, reference 80 ns.
`timescale 1ns/1ps

module icm_clock_ctrl_tb;
  import icm_pkg::*;
  localparam int LOOP_PER = 60;
  localparam int REF_PER = 80;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic stop_req = 1'b0;
  icm_apb_req_t req = '0;
  icm_apb_rsp_t rsp;
  logic ref_osc_in, loop_osc_in, system_clock_out, bus_clock_out;
  logic loop_enable, ref_enable;
  logic [9:0] dco_ctrl;
  logic [8:0] ref_trim;
  icm_mode_t clock_mode;
  int n_errors = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic err;
  logic [1:0] held;

  always #5 clock = ~clock;

  icm_clock_ctrl u_icm_clock_ctrl (
    .clock(clock), .rst_n(rst_n), .por_n(por_n), .apb_req(req), .apb_rsp(rsp),
    .stop_req(stop_req), .ref_osc_in(ref_osc_in), .loop_osc_in(loop_osc_in),
    .system_clock_out(system_clock_out), .bus_clock_out(bus_clock_out),
    .loop_enable(loop_enable), .ref_enable(ref_enable), .dco_ctrl(dco_ctrl),
    .ref_trim(ref_trim), .clock_mode(clock_mode));

  icm_osc_model u_icm_osc_model (
    .ref_enable(ref_enable), .loop_enable(loop_enable),
    .ref_osc_in(ref_osc_in), .loop_osc_in(loop_osc_in));

  // ==========================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [3:0] addr, input logic [7:0] wdata);
    @(posedge clock);
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= addr;
    req.pwdata <= {24'h0, wdata};
    @(posedge clock);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 8'h0);
    check(rd, exp);
    check(32'(err), 32'h0);
  endtask

  task automatic measure(input int exp);
    time t0;
    repeat (3) @(posedge system_clock_out);
    t0 = $time;
    @(posedge system_clock_out);
    check(32'($time - t0), 32'(exp));
    @(posedge bus_clock_out);
    t0 = $time;
    @(posedge bus_clock_out);
    check(32'($time - t0), 32'(2 * exp));
  endtask

  task automatic settle_mode(input icm_mode_t m);
    repeat (3) @(posedge clock);
    check(32'(clock_mode), 32'(m));
  endtask

  task automatic stop_cycle(input logic keep, input icm_mode_t back);
    stop_req <= 1'b1;
    settle_mode(ICM_STOP_MODE);
    check(32'(loop_enable), 32'h0);
    check(32'(ref_enable), 32'(keep));
    held = {bus_clock_out, system_clock_out};
    repeat (50) @(posedge clock);
    check(32'({bus_clock_out, system_clock_out}), 32'(held));
    stop_req <= 1'b0;
    settle_mode(back);
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================
  // Tests
  initial
  begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    rd_chk(ICM_OFS_CTRL1, 32'h0);
    rd_chk(ICM_OFS_CTRL2, {24'h0, ICM_DIV_RST, 6'h0});
    rd_chk(ICM_OFS_STAT, 32'h0);
    check(32'(clock_mode), 32'(ICM_LOOP_ENGAGED_INTERNAL_MODE));
    check(32'(ref_trim), 32'({ICM_TRIM_RST, ICM_FT_RST}));
    apb(1'b0, 4'h2, 8'h0);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
    $display("reset test done");
    for (int d = 0; d < 4; d++)
    begin
      apb(1'b1, ICM_OFS_CTRL2, 8'(d << 6));
      measure(LOOP_PER << d);
    end
    $display("divider test done");
    apb(1'b1, ICM_OFS_CTRL1, 8'h41);
    settle_mode(ICM_BYPASS_INTERNAL_MODE);
    check(32'(loop_enable), 32'h1);
    measure(REF_PER << 3);
    rd_chk(ICM_OFS_STAT, 32'h4);
    stop_cycle(1'b1, ICM_BYPASS_INTERNAL_MODE);
    apb(1'b1, ICM_OFS_CTRL2, 8'h48);
    settle_mode(ICM_BYPASS_LOW_POWER_MODE);
    check(32'(loop_enable), 32'h0);
    measure(REF_PER * 2);
    apb(1'b1, ICM_OFS_CTRL1, 8'h40);
    stop_cycle(1'b0, ICM_BYPASS_LOW_POWER_MODE);
    $display("mode test done");
    apb(1'b1, ICM_OFS_CTRL1, 8'hff);
    rd_chk(ICM_OFS_CTRL1, 32'h41);
    apb(1'b1, ICM_OFS_CTRL2, 8'hff);
    rd_chk(ICM_OFS_CTRL2, 32'hc8);
    apb(1'b1, ICM_OFS_TRIM, 8'h5a);
    rd_chk(ICM_OFS_TRIM, 32'h5a);
    apb(1'b1, ICM_OFS_STAT, 8'hff);
    rd_chk(ICM_OFS_STAT, 32'h5);
    check(32'(ref_trim), 32'h0b5);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    check(32'(dco_ctrl), 32'(ICM_DCO_RST));
    rst_n <= 1'b1;
    rd_chk(ICM_OFS_TRIM, 32'h5a);
    rd_chk(ICM_OFS_STAT, 32'h1);
    rd_chk(ICM_OFS_CTRL2, 32'h40);
    check(32'(clock_mode), 32'(ICM_LOOP_ENGAGED_INTERNAL_MODE));
    measure(LOOP_PER * 2);
    // Loop far below its target count, so the control word must have climbed
    check(32'(dco_ctrl > ICM_DCO_RST), 32'h1);
    $display("trim and reset test done");
    stop_test();
  end

  // Hang guard, far beyond the expected run
  initial
  begin
    #200000;
    n_errors++;
    stop_test();
  end
endmodule

// File: tb/icm_osc_model.sv
// Model of the two analog oscillators that feed the clock controller.
// Assumes bench clock edges at 5 ns + 10 ns steps; edges land 2 ns before them.
`timescale 1ns/1ps

module icm_osc_model #(
  parameter int REF_HALF = 40,
  parameter int LOOP_HALF = 30
) (
  // Enables from the controller
  input wire logic ref_enable,
  input wire logic loop_enable,
  // Oscillator outputs
  output logic ref_osc_in,
  output logic loop_osc_in
);
  logic ref_ph = 1'b0;
  logic loop_ph = 1'b0;

  // ==========================================
  // Free-running phase, output low while disabled
  initial
  begin
    ref_osc_in = 1'b0;
    #3;
    forever
    begin
      #REF_HALF;
      ref_ph = ~ref_ph;
      ref_osc_in = ref_ph & ref_enable;
    end
  end

  initial
  begin
    loop_osc_in = 1'b0;
    #3;
    forever
    begin
      #LOOP_HALF;
      loop_ph = ~loop_ph;
      loop_osc_in = loop_ph & loop_enable;
    end
  end
endmodule
